// file: inc/spor_regs.vh
// register offsets, fields and reset values for the status and pin-output registers
// Overview of operation
// - bit 15 flags one-time store load failure
// - soft reset clears temporary one-time load failure
// - bit 14 flags user store load failure
// - user store error never blocks any operation
// - soft reset clears user store error flag
// - bits 9-12 show channel 0-3 busy
// - bit 8 set once protection is triggered
// - reading comparator status clears protection flag
// - bits 4-7 window result, latched or live
// - bits 0-3 synchronized comparator results
// - bit 15 inserts input glitch filter
// - bit 13 enables pin output drive
// - bits 12-9 select store/channel busy source
// - codes 1000-1011 select window results
`ifndef SPOR_REGS_VH
`define SPOR_REGS_VH
`define SPOR_ADDR_GENERAL_STATUS 8'h22
`define SPOR_ADDR_COMPARATOR_STATUS 8'h23
`define SPOR_ADDR_PIN_CONFIGURATION 8'h24
`define SPOR_RST_PIN_CONFIGURATION 16'h0000
`define SPOR_RST_COMPARATOR_STATUS 16'h0000
`define SPOR_GS_OTP_ERR 15
`define SPOR_GS_USER_ERR 14
`define SPOR_GS_BUSY_LSB 9
`define SPOR_GS_ID_LSB 2
`define SPOR_CS_PROTECT 8
`define SPOR_CS_WIN_LSB 4
`define SPOR_CS_CMP_LSB 0
`define SPOR_PC_FILTER_ON 15
`define SPOR_PC_DRIVE_ON 13
`define SPOR_PC_SRC_LSB 9
`define SPOR_PC_WMASK 16'hbffe
`define SPOR_SRC_STORE_BUSY 4'h1
`define SPOR_SRC_CH_BUSY 2'h1
`define SPOR_SRC_WIN 2'h2
`define SPOR_FILTER_SAMPLES 3
`endif

// file: logic/spor_status_pin_regs.v
// status and pin-output configuration register bank
`timescale 1ns/1ps
`include "spor_regs.vh"
module spor_status_pin_regs #(
  parameter [5:0] PART_ID = 6'h2a, // arbitrary value
  parameter [1:0] REVISION = 2'h0, // arbitrary value
  parameter FILTER_SAMPLES = `SPOR_FILTER_SAMPLES
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // register access port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata_ff,
  // store load and software reset events
  input wire load_done,
  input wire otp_load_bad,
  input wire user_load_bad,
  input wire soft_reset,
  // device status
  input wire store_write_busy,
  input wire [3:0] ch_busy,
  input wire protect_event,
  input wire window_latch_en,
  input wire [3:0] window_clear,
  // asynchronous comparator results
  input wire [3:0] cmp_raw,
  input wire [3:0] win_raw,
  // general-purpose pin
  input wire gpio_in,
  output reg gpio_out_ff,
  output reg gpio_oe_ff,
  output reg gpio_in_filtered_ff
);
  reg [1:0] rst_sync_ff;
  wire rst_n = rst_sync_ff[1];
  reg [3:0] cmp_s1_ff, cmp_s2_ff, win_s1_ff, win_s2_ff;
  reg gpio_s1_ff, gpio_s2_ff;
  reg [3:0] win_latched_ff;
  reg [3:0] busy_ff;
  reg otp_load_integrity_error_ff, user_store_load_error_ff, protect_flag_ff;
  reg [15:0] pin_cfg_ff;
  reg [FILTER_SAMPLES-1:0] filt_hist_ff;
  wire [3:0] window_compare_result = window_latch_en ? win_latched_ff : win_s2_ff;
  wire input_glitch_filter_on = pin_cfg_ff[`SPOR_PC_FILTER_ON];
  wire pin_output_drive_on = pin_cfg_ff[`SPOR_PC_DRIVE_ON];
  wire [3:0] pin_output_source_select = pin_cfg_ff[`SPOR_PC_SRC_LSB+3:`SPOR_PC_SRC_LSB];

  // register address match, shared by read and write decoding
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  wire rd_cmp = reg_rd && addr_hit(reg_addr, `SPOR_ADDR_COMPARATOR_STATUS);
  wire [15:0] general_status = {otp_load_integrity_error_ff, user_store_load_error_ff, 1'b0,
    busy_ff, 1'b0, PART_ID, REVISION};
  wire [15:0] comparator_status = {7'h00, protect_flag_ff, window_compare_result,
    cmp_s2_ff};
  reg [15:0] nxt_rdata;
  reg nxt_gpio_out;

  // reset asserts at once, releases after two edges
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  // comparator result synchroniser
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_ff <= 4'h0;
      cmp_s2_ff <= 4'h0;
    end else begin
      cmp_s1_ff <= cmp_raw;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // window result synchroniser
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_s1_ff <= 4'h0;
      win_s2_ff <= 4'h0;
    end else begin
      win_s1_ff <= win_raw;
      win_s2_ff <= win_s1_ff;
    end
  end

  // pin input synchroniser
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_s1_ff <= 1'b0;
      gpio_s2_ff <= 1'b0;
    end else begin
      gpio_s1_ff <= gpio_in;
      gpio_s2_ff <= gpio_s1_ff;
    end
  end

  // channel busy, one register stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      busy_ff <= 4'h0;
    else
      busy_ff <= ch_busy;
  end

  // load integrity flags; a finished load wins over soft reset
  // user error only reports; nothing here gates other operations
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      otp_load_integrity_error_ff <= 1'b0;
      user_store_load_error_ff <= 1'b0;
    end else if (load_done) begin
      otp_load_integrity_error_ff <= otp_load_bad;
      user_store_load_error_ff <= user_load_bad;
    end else if (soft_reset) begin
      otp_load_integrity_error_ff <= 1'b0;
      user_store_load_error_ff <= 1'b0;
    end
  end

  // protection flag; set wins over read clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      protect_flag_ff <= 1'b0;
    else if (protect_event)
      protect_flag_ff <= 1'b1;
    else if (rd_cmp)
      protect_flag_ff <= 1'b0;
  end

  // sticky window latch; set wins over clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      win_latched_ff <= 4'h0;
    else
      win_latched_ff <= (win_latched_ff & ~window_clear) | win_s2_ff;
  end

  // register read data select
  always @* begin
    case (reg_addr)
      `SPOR_ADDR_GENERAL_STATUS: nxt_rdata = general_status;
      `SPOR_ADDR_COMPARATOR_STATUS: nxt_rdata = comparator_status;
      `SPOR_ADDR_PIN_CONFIGURATION: nxt_rdata = pin_cfg_ff;
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // pin configuration; only the writable bits are kept
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pin_cfg_ff <= `SPOR_RST_PIN_CONFIGURATION;
    else if (reg_wr && addr_hit(reg_addr, `SPOR_ADDR_PIN_CONFIGURATION))
      pin_cfg_ff <= reg_wdata & `SPOR_PC_WMASK;
  end

  // read data holds until the next read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata_ff <= 16'h0000;
    else if (reg_rd)
      reg_rdata_ff <= nxt_rdata;
  end

  // pin output source mux; unlisted codes drive low
  always @* begin
    nxt_gpio_out = 1'b0;
    if (pin_output_source_select == `SPOR_SRC_STORE_BUSY)
      nxt_gpio_out = store_write_busy;
    else if (pin_output_source_select[3:2] == `SPOR_SRC_CH_BUSY)
      nxt_gpio_out = busy_ff[pin_output_source_select[1:0]];
    else if (pin_output_source_select[3:2] == `SPOR_SRC_WIN)
      nxt_gpio_out = window_compare_result[pin_output_source_select[1:0]];
  end

  // pin drive; value forced low while drive is off
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_out_ff <= 1'b0;
      gpio_oe_ff <= 1'b0;
    end else begin
      gpio_oe_ff <= pin_output_drive_on;
      gpio_out_ff <= pin_output_drive_on & nxt_gpio_out;
    end
  end

  // pin input path with optional glitch filter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_in_filtered_ff <= 1'b0;
      filt_hist_ff <= {FILTER_SAMPLES{1'b0}};
    end else begin
      filt_hist_ff <= {filt_hist_ff[FILTER_SAMPLES-2:0], gpio_s2_ff};
      // filter: input must hold steady over all samples
      if (!input_glitch_filter_on)
        gpio_in_filtered_ff <= gpio_s2_ff;
      else if (&filt_hist_ff)
        gpio_in_filtered_ff <= 1'b1;
      else if (~|filt_hist_ff)
        gpio_in_filtered_ff <= 1'b0;
    end
  end
endmodule

// file: verification/spor_chk_sva.sv
// port assertions for the status and pin register bank
`timescale 1ns/1ps
module spor_chk #(parameter [5:0] PART_ID = 6'h2a, parameter [1:0] REVISION = 2'h0) (
  // clock, reset, register port
  input wire clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata_ff,
  // status and pin
  input wire [3:0] ch_busy,
  input wire protect_event,
  input wire gpio_out_ff,
  input wire gpio_oe_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  id_fields_a: assert property (reg_rd && reg_addr == 8'h22 |=> reg_rdata_ff[7:0] == {PART_ID, REVISION})
    else $error("id");
  busy_bits_a: assert property (reg_rd && reg_addr == 8'h22 |=> reg_rdata_ff[12:9] == $past(ch_busy, 2))
    else $error("busy");
  gs_spare_a: assert property (reg_rd && reg_addr == 8'h22 |=> !reg_rdata_ff[13] && !reg_rdata_ff[8])
    else $error("gs spare");
  cs_spare_a: assert property (reg_rd && reg_addr == 8'h23 |=> reg_rdata_ff[15:9] == 7'h00)
    else $error("cs spare");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_ff))
    else $error("rdata moved");
  protect_set_a: assert property (protect_event ##2 (reg_rd && reg_addr == 8'h23) |=> reg_rdata_ff[8])
    else $error("protect");
  drive_en_a: assert property (reg_wr && reg_addr == 8'h24 |-> ##2 gpio_oe_ff == $past(reg_wdata[13], 2))
    else $error("oe");
  drive_off_a: assert property (!gpio_oe_ff |-> !gpio_out_ff)
    else $error("out");
endmodule
bind spor_status_pin_regs spor_chk #(.PART_ID(PART_ID), .REVISION(REVISION)) chk (.clk(clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
  .ch_busy(ch_busy), .protect_event(protect_event), .gpio_out_ff(gpio_out_ff), .gpio_oe_ff(gpio_oe_ff));

// file: verification/spor_host.sv
// host model issuing register requests on falling edges
`timescale 1ns/1ps
module spor_host (
  // clock
  input wire clk,
  // register port
  output reg [7:0] reg_addr = 8'h00,
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0,
  output reg [15:0] reg_wdata = 16'h0000,
  input wire [15:0] reg_rdata_ff
);
  task xfer(input [7:0] a, input [15:0] d, input w, output [15:0] q);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge clk);
      q = reg_rdata_ff;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = ~d;
    end
  endtask
endmodule

// file: verification/tb_spor_status_pin_regs.sv
// bench for the status and pin register bank
`timescale 1ns/1ps
module tb_spor_status_pin_regs;
  reg clk = 0, reset_n = 0, ld = 0, ob = 0, ub = 0, sr = 0, sw = 0, pe = 0, gi = 0;
  reg [3:0] busy = 4'h0, cmp = 4'h0, win = 4'h0, wc = 4'h0;
  reg wl = 0;
  wire [7:0] a;
  wire w, r, go, ge, gf;
  wire [15:0] wd, rdat;
  reg [15:0] d;
  integer error_cnt = 0, total_checks = 0, cyc = 0, i;
  always #25 clk = ~clk;
  spor_host h (.clk(clk), .reg_addr(a), .reg_wr(w), .reg_rd(r), .reg_wdata(wd), .reg_rdata_ff(rdat));
  spor_status_pin_regs dut (.clk(clk), .reset_n(reset_n), .reg_addr(a), .reg_wr(w), .reg_rd(r), .reg_wdata(wd),
    .reg_rdata_ff(rdat), .load_done(ld), .otp_load_bad(ob), .user_load_bad(ub), .soft_reset(sr),
    .store_write_busy(sw), .ch_busy(busy), .protect_event(pe), .window_latch_en(wl), .window_clear(wc),
    .cmp_raw(cmp), .win_raw(win), .gpio_in(gi), .gpio_out_ff(go), .gpio_oe_ff(ge), .gpio_in_filtered_ff(gf));
  task chk(input [15:0] g, input [15:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: %h not %h", $time, g, e);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1;
    repeat (3) @(negedge clk);
    h.xfer(8'h24, 0, 0, d); chk(d, 16'h0000);
    h.xfer(8'h30, 0, 0, d); chk(d, 16'h0000);
    {ob, ub, busy, cmp, win, ld} = {6'h35, 8'h35, 1'b1};
    @(negedge clk); ld = 0;
    h.xfer(8'h22, 0, 0, d); chk(d, 16'hcaa8);
    sr = 1; busy = 4'h0;
    @(negedge clk); sr = 0;
    h.xfer(8'h22, 16'hffff, 1, d);
    h.xfer(8'h22, 0, 0, d); chk(d, 16'h00a8);
    pe = 1;
    @(negedge clk); pe = 0;
    h.xfer(8'h23, 0, 0, d); chk(d, 16'h0153);
    h.xfer(8'h23, 0, 0, d); chk(d, 16'h0053);
    wl = 1; win = 4'h0;
    repeat (4) @(negedge clk);
    h.xfer(8'h23, 0, 0, d); chk(d, 16'h0053);
    wc = 4'hf;
    @(negedge clk); wc = 4'h0;
    repeat (3) @(negedge clk);
    h.xfer(8'h23, 0, 0, d); chk(d, 16'h0003);
    wl = 0; win = 4'h5;
    repeat (4) @(negedge clk);
    h.xfer(8'h24, 16'hffff, 1, d);
    h.xfer(8'h24, 0, 0, d); chk(d, 16'hbffe);
    sw = 1; busy = 4'h1;
    for (i = 0; i < 3; i = i + 1) begin
      h.xfer(8'h24, i == 0 ? 16'h2200 : i == 1 ? 16'h2800 : 16'h3000, 1, d);
      repeat (4) @(negedge clk);
      chk({ge, go}, 16'h3);
    end
    gi = 1;
    repeat (4) @(negedge clk); chk(gf, 16'h1);
    h.xfer(8'h24, 16'h8000, 1, d);
    gi = 0;
    repeat (3) @(negedge clk); chk({ge, gf}, 16'h1);
    repeat (8) @(negedge clk); chk(gf, 16'h0);
    final_report;
  end
endmodule
